// File: hdl/esc_pkg.sv
// package: register map, field positions and codes for the estop/counter block
package esc_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_EXT_STATUS = 8'h04;
  localparam logic [7:0] OFS_ERR_CAUSE = 8'h08;
  localparam logic [7:0] OFS_INT_STATUS = 8'h0c;
  localparam logic [7:0] OFS_INT_MASK = 8'h10;
  localparam logic [7:0] OFS_CNT_ENV = 8'h14;
  localparam logic [7:0] OFS_TARGET = 8'h18;
  localparam logic [7:0] OFS_OP_MODE = 8'h1c;
  localparam logic [7:0] OFS_POS_CNT = 8'h20;
  localparam logic [7:0] OFS_CMD_POS = 8'h24;
  localparam logic [7:0] OFS_MECH_POS = 8'h28;
  localparam logic [7:0] OFS_DEFL = 8'h2c;
  localparam logic [7:0] OFS_GP = 8'h30;
  // ==========================================================
  // field positions
  localparam int EXT_EMG_BIT = 7;
  localparam int EXT_TRIG_BIT = 8;
  localparam int EXT_RUN_BIT = 0;
  localparam int CAUSE_EMG_BIT = 9;
  localparam int OVR_HOLD_BIT = 14;
  localparam int ENV_MECH_LSB = 8;
  localparam int INT_EMG_BIT = 0;
  localparam int INT_POS_BIT = 1;
  localparam int INT_W = 2;
  // ==========================================================
  // codes and reset values
  localparam logic [7:0] CMD_EMG_STOP = 8'h05;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  // counter source selections
  typedef enum logic [1:0] {
    ESC_SRC_A = 2'b00,
    ESC_SRC_B = 2'b01,
    ESC_SRC_C = 2'b10,
    ESC_SRC_NONE = 2'b11
  } esc_src_t;
  // counter environment layout, bits 15:8 of the word
  typedef struct packed {
    logic [1:0] spare;
    esc_src_t gp_src;
    esc_src_t defl_src;
    esc_src_t mech_src;
  } esc_env_t;
  // one counting event: a pulse and its direction (1 = up)
  typedef struct packed {
    logic pulse;
    logic up;
  } esc_evt_t;
endpackage

// File: hdl/esc_top.sv
// emergency stop handling and position counter set with an AXI4-Lite slave
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
// ==========================================================
module esc_top #(
  parameter int NUM_AXES = 4,
  parameter int CNT_W = 28,
  parameter int DEFL_W = 16
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  // axi4-lite write address and data
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [7:0] awaddr_in,
  input wire logic wvalid_in,
  output logic wready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  // axi4-lite write response
  output logic bvalid_out,
  input wire logic bready_in,
  output logic [1:0] bresp_out,
  // axi4-lite read
  input wire logic arvalid_in,
  output logic arready_out,
  input wire logic [7:0] araddr_in,
  output logic rvalid_out,
  input wire logic rready_in,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  // emergency and axis control
  input wire logic emergency_stop_input_n_in,
  input wire logic [NUM_AXES-1:0] axis_running_in,
  input wire logic [NUM_AXES-1:0] axis_start_req_in,
  output logic [NUM_AXES-1:0] axis_start_ok_out,
  output logic stop_all_out,
  // counting sources of the counted axis
  input wire esc_pkg::esc_evt_t out_pulse_in,
  input wire esc_pkg::esc_evt_t encoder_inputs_in,
  input wire esc_pkg::esc_evt_t pulsar_scaled_in,
  input wire logic override2_active_in,
  input wire logic override_trigger_input_in,
  // interrupt
  output logic int_out
);

  // step a counter by one event, wrapping modulo the width
  function automatic logic [CNT_W-1:0] step(
    input logic [CNT_W-1:0] v,
    input esc_pkg::esc_evt_t e
  );
    logic [CNT_W-1:0] r;
    r = v;
    if (e.pulse) begin
      r = e.up ? v + 1'b1 : v - 1'b1;
    end
    return r;
  endfunction

  // merge a write word into a register under the byte strobes
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // inverse direction of an event
  function automatic esc_pkg::esc_evt_t flip(input esc_pkg::esc_evt_t e);
    esc_pkg::esc_evt_t r;
    r = e;
    r.up = ~e.up;
    return r;
  endfunction

  // ==========================================================
  // bus slave state
  logic aw_held, w_held, do_write, wr_hit, rd_hit, cmd_wr, intstat_wr;
  logic [7:0] aw_addr;
  logic [31:0] w_data, rd_word;
  logic [3:0] w_strb;
  // write words merged under the byte strobes for the environment, target and mask registers
  logic [31:0] env_word, tgt_word, mask_word;
  // software registers
  esc_pkg::esc_env_t cnt_env;
  logic [CNT_W-1:0] target_pos;
  logic [31:0] op_mode;
  logic [esc_pkg::INT_W-1:0] int_status;
  logic [esc_pkg::INT_W-1:0] int_mask;
  logic emg_cause;
  // block state
  logic emg_active, emg_trig, any_running, any_start;
  logic trig_seen, pos_hold, pos_zero_evt;
  logic [CNT_W-1:0] pos_cnt, cmd_pos, mech_pos, gp_cnt;
  logic [DEFL_W-1:0] defl_cnt;
  logic [CNT_W-1:0] next_defl, target_abs;

  // ==========================================================
  // emergency logic
  // the pin is read as active low with no polarity setting at all
  assign emg_active = ~emergency_stop_input_n_in;
  assign any_running = |axis_running_in;
  assign any_start = |axis_start_req_in;
  assign cmd_wr = do_write && aw_addr == esc_pkg::OFS_CMD && w_strb[0];
  // command code 05h is treated as one more source of the same event
  assign emg_trig = any_running && (emg_active || (cmd_wr &&
    w_data[7:0] == esc_pkg::CMD_EMG_STOP));

  // stop all axes at once and refuse starts while the input is low
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stop_all_out <= 1'b0;
      axis_start_ok_out <= '0;
    end else begin
      stop_all_out <= emg_trig || emg_active;
      axis_start_ok_out <= emg_active ? '0 : axis_start_req_in;
    end
  end

  // error cause: set by an emergency stop, cleared by a fresh start
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      emg_cause <= 1'b0;
    end else if (emg_trig) begin
      emg_cause <= 1'b1;
    end else if (any_start) begin
      emg_cause <= 1'b0;
    end
  end

  // ==========================================================
  // interrupt status, mask and output
  assign intstat_wr = do_write && aw_addr == esc_pkg::OFS_INT_STATUS;
  assign pos_zero_evt = out_pulse_in.pulse && !pos_hold &&
    pos_cnt == CNT_W'(1);

  // set beats clear so an event in the clearing cycle is kept
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      int_status <= '0;
    end else begin
      int_status[esc_pkg::INT_EMG_BIT] <= emg_trig ||
        (int_status[esc_pkg::INT_EMG_BIT] &&
        !(intstat_wr && w_data[esc_pkg::INT_EMG_BIT]));
      int_status[esc_pkg::INT_POS_BIT] <= pos_zero_evt ||
        (int_status[esc_pkg::INT_POS_BIT] &&
        !(intstat_wr && w_data[esc_pkg::INT_POS_BIT]));
    end
  end

  // level interrupt, registered so the pin never glitches
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      int_out <= 1'b0;
    end else begin
      int_out <= |(int_status & int_mask);
    end
  end

  // ==========================================================
  // positioning counter
  assign target_abs = target_pos[CNT_W-1] ? CNT_W'(-target_pos) :
    target_pos;
  // in a second override with hold enabled, pulses wait for the trigger
  assign pos_hold = op_mode[esc_pkg::OVR_HOLD_BIT] &&
    override2_active_in && !trig_seen;

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      trig_seen <= 1'b0;
    end else if (any_start) begin
      trig_seen <= 1'b0;
    end else if (override_trigger_input_in) begin
      trig_seen <= 1'b1;
    end
  end

  // load on start when allowed, otherwise count output pulses down
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pos_cnt <= '0;
    end else if (any_start && !emg_active) begin
      pos_cnt <= target_abs;
    end else if (out_pulse_in.pulse && !pos_hold) begin
      pos_cnt <= pos_cnt - 1'b1;
    end
  end

  // ==========================================================
  // up/down counters; sources have no half-clock option at all
  // a truncated final pulse is still counted, hence origin return
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cmd_pos <= '0;
    end else begin
      cmd_pos <= step(cmd_pos, out_pulse_in);
    end
  end

  // mechanical position counter
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mech_pos <= '0;
    end else begin
      case (cnt_env.mech_src)
        esc_pkg::ESC_SRC_A: mech_pos <= step(mech_pos, encoder_inputs_in);
        esc_pkg::ESC_SRC_B: mech_pos <= step(mech_pos, out_pulse_in);
        esc_pkg::ESC_SRC_C: mech_pos <= step(mech_pos, pulsar_scaled_in);
        default: mech_pos <= mech_pos;
      endcase
    end
  end

  // deflection: first source counts in its own direction, second against its own
  always_comb begin
    next_defl = CNT_W'(defl_cnt);
    case (cnt_env.defl_src)
      esc_pkg::ESC_SRC_A: next_defl = step(step(next_defl, out_pulse_in),
        flip(encoder_inputs_in));
      esc_pkg::ESC_SRC_B: next_defl = step(step(next_defl, out_pulse_in),
        flip(pulsar_scaled_in));
      esc_pkg::ESC_SRC_C: next_defl = step(step(next_defl,
        encoder_inputs_in), flip(pulsar_scaled_in));
      default: next_defl = CNT_W'(defl_cnt);
    endcase
  end

  // deflection register keeps the low bits, so it wraps at its width
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      defl_cnt <= '0;
    end else begin
      defl_cnt <= next_defl[DEFL_W-1:0];
    end
  end

  // general-purpose counter
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      gp_cnt <= '0;
    end else begin
      case (cnt_env.gp_src)
        esc_pkg::ESC_SRC_A: gp_cnt <= step(gp_cnt, out_pulse_in);
        esc_pkg::ESC_SRC_B: gp_cnt <= step(gp_cnt, encoder_inputs_in);
        esc_pkg::ESC_SRC_C: gp_cnt <= step(gp_cnt, pulsar_scaled_in);
        default: gp_cnt <= gp_cnt;
      endcase
    end
  end

  // ==========================================================
  // axi4-lite write channel
  assign do_write = aw_held && w_held && !bvalid_out;
  always_comb begin
    case (aw_addr)
      esc_pkg::OFS_CMD, esc_pkg::OFS_INT_STATUS, esc_pkg::OFS_INT_MASK,
      esc_pkg::OFS_CNT_ENV, esc_pkg::OFS_TARGET,
      esc_pkg::OFS_OP_MODE: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // address and data are taken in either order, one at a time
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      awready_out <= 1'b1;
      wready_out <= 1'b1;
      bvalid_out <= 1'b0;
      bresp_out <= esc_pkg::RESP_OKAY;
    end else begin
      if (awvalid_in && awready_out) begin
        aw_held <= 1'b1;
        aw_addr <= awaddr_in;
        awready_out <= 1'b0;
      end
      if (wvalid_in && wready_out) begin
        w_held <= 1'b1;
        w_data <= wdata_in;
        w_strb <= wstrb_in;
        wready_out <= 1'b0;
      end
      if (do_write) begin
        bvalid_out <= 1'b1;
        bresp_out <= wr_hit ? esc_pkg::RESP_OKAY : esc_pkg::RESP_SLVERR;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
      if (bvalid_out && bready_in) begin
        bvalid_out <= 1'b0;
        awready_out <= 1'b1;
        wready_out <= 1'b1;
      end
    end
  end

  // a function result cannot be sliced, so the merged words are nets first
  assign env_word = merge({16'h0000, cnt_env, 8'h00}, w_data, w_strb);
  assign tgt_word = merge(32'(target_pos), w_data, w_strb);
  assign mask_word = merge(32'(int_mask), w_data, w_strb);
  // software-written control registers
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_env <= '0;
      target_pos <= '0;
      op_mode <= '0;
      int_mask <= '0;
    end else if (do_write) begin
      case (aw_addr)
        esc_pkg::OFS_CNT_ENV: cnt_env <= esc_pkg::esc_env_t'(
          env_word[esc_pkg::ENV_MECH_LSB +: 8]);
        esc_pkg::OFS_TARGET: target_pos <= tgt_word[CNT_W-1:0];
        esc_pkg::OFS_OP_MODE: op_mode <= merge(op_mode, w_data, w_strb);
        esc_pkg::OFS_INT_MASK: int_mask <= mask_word[esc_pkg::INT_W-1:0];
        default: int_mask <= int_mask;
      endcase
    end
  end

  // ==========================================================
  // axi4-lite read channel
  always_comb begin
    rd_word = esc_pkg::ZERO_WORD;
    rd_hit = 1'b1;
    case (araddr_in)
      esc_pkg::OFS_EXT_STATUS: begin
        rd_word[esc_pkg::EXT_EMG_BIT] = emg_active;
        rd_word[esc_pkg::EXT_TRIG_BIT] = override_trigger_input_in;
        rd_word[esc_pkg::EXT_RUN_BIT] = any_running;
      end
      esc_pkg::OFS_ERR_CAUSE: rd_word[esc_pkg::CAUSE_EMG_BIT] = emg_cause;
      esc_pkg::OFS_INT_STATUS: rd_word = 32'(int_status);
      esc_pkg::OFS_INT_MASK: rd_word = 32'(int_mask);
      esc_pkg::OFS_CNT_ENV: rd_word = {16'h0000, cnt_env, 8'h00};
      esc_pkg::OFS_TARGET: rd_word = 32'(target_pos);
      esc_pkg::OFS_OP_MODE: rd_word = op_mode;
      esc_pkg::OFS_POS_CNT: rd_word = 32'(pos_cnt);
      esc_pkg::OFS_CMD_POS: rd_word = 32'(cmd_pos);
      esc_pkg::OFS_MECH_POS: rd_word = 32'(mech_pos);
      esc_pkg::OFS_DEFL: rd_word = 32'(defl_cnt);
      esc_pkg::OFS_GP: rd_word = 32'(gp_cnt);
      default: rd_hit = 1'b0;
    endcase
  end

  // one read at a time; data follows the address by one cycle
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      arready_out <= 1'b1;
      rvalid_out <= 1'b0;
      rdata_out <= esc_pkg::ZERO_WORD;
      rresp_out <= esc_pkg::RESP_OKAY;
    end else if (arvalid_in && arready_out) begin
      arready_out <= 1'b0;
      rvalid_out <= 1'b1;
      rdata_out <= rd_word;
      rresp_out <= rd_hit ? esc_pkg::RESP_OKAY : esc_pkg::RESP_SLVERR;
    end else if (rvalid_out && rready_in) begin
      rvalid_out <= 1'b0;
      arready_out <= 1'b1;
    end
  end

endmodule

// File: sim/esc_monitor.sv
// checker: port-level timing properties of the estop and counter block
`timescale 1ns/1ps
module esc_monitor #(
  parameter int NUM_AXES = 4
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  // register bus
  input wire logic awvalid_in,
  input wire logic awready_out,
  input wire logic wvalid_in,
  input wire logic wready_out,
  input wire logic bvalid_out,
  input wire logic bready_in,
  input wire logic [1:0] bresp_out,
  input wire logic arvalid_in,
  input wire logic arready_out,
  input wire logic [7:0] araddr_in,
  input wire logic rvalid_out,
  input wire logic rready_in,
  input wire logic [31:0] rdata_out,
  input wire logic [1:0] rresp_out,
  // emergency and axis control
  input wire logic emergency_stop_input_n_in,
  input wire logic [NUM_AXES-1:0] axis_running_in,
  input wire logic [NUM_AXES-1:0] axis_start_req_in,
  input wire logic [NUM_AXES-1:0] axis_start_ok_out,
  input wire logic stop_all_out
);
  // ==========================================================
  // one clock domain, so clock and reset are given once
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  property p_emg_stop;
    !emergency_stop_input_n_in && |axis_running_in |=> stop_all_out;
  endproperty
  a_emg_stop: assert property (p_emg_stop)
    else $error("low emergency input did not stop the axes");
  property p_start_gate;
    1'b1 |=> axis_start_ok_out == ($past(axis_start_req_in) &
      {NUM_AXES{$past(emergency_stop_input_n_in)}});
  endproperty
  a_start_gate: assert property (p_start_gate)
    else $error("start grant does not follow request and input");
  // a command stop with nothing running would be a spurious halt;
  // a low input holds the stop up on its own, running or not
  property p_stop_cause;
    $rose(stop_all_out) && $past(emergency_stop_input_n_in) |->
      $past(|axis_running_in);
  endproperty
  a_stop_cause: assert property (p_stop_cause)
    else $error("stop raised with no axis running");
  property p_b_hold;
    bvalid_out && !bready_in |=> bvalid_out && $stable(bresp_out);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped before taken");
  property p_r_hold;
    rvalid_out && !rready_in |=> rvalid_out && $stable(rdata_out);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped before taken");
  property p_b_time;
    awvalid_in && awready_out && wvalid_in && wready_out |-> ##2 bvalid_out;
  endproperty
  a_b_time: assert property (p_b_time)
    else $error("write response late");
  property p_r_time;
    arvalid_in && arready_out |=> rvalid_out ##0 !arready_out;
  endproperty
  a_r_time: assert property (p_r_time)
    else $error("read answer late");
  property p_r_unmapped;
    arvalid_in && arready_out && araddr_in == 8'h34 |=>
      rresp_out == esc_pkg::RESP_SLVERR && rdata_out == esc_pkg::ZERO_WORD;
  endproperty
  a_r_unmapped: assert property (p_r_unmapped)
    else $error("unmapped read not refused");
endmodule
bind esc_top esc_monitor #(.NUM_AXES(NUM_AXES)) i_esc_monitor (.*);

// File: sim/esc_far_model.sv
// far-side model: pulse output, encoder, scaled pulsar and emergency circuit
`timescale 1ns/1ps
module esc_far_model (
  // clock
  input wire logic mclk_in,
  // counting events and emergency line toward the block
  output esc_pkg::esc_evt_t out_pulse_out,
  output esc_pkg::esc_evt_t encoder_out,
  output esc_pkg::esc_evt_t pulsar_out,
  output logic emg_n_out
);
  // 0 output pulses, 1 encoder, 2 pulsar already scaled (never raw pins)
  esc_pkg::esc_evt_t ev [3] = '{default: '0};
  logic emg_n = 1'b1;
  assign out_pulse_out = ev[0];
  assign encoder_out = ev[1];
  assign pulsar_out = ev[2];
  assign emg_n_out = emg_n;
  // one event every third cycle, never at half the reference clock
  // rate; an idle direction line shows the inverse of its last value
  task automatic emit(input int src, input int n, input logic up);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk_in);
      ev[src] <= '{1'b1, up};
      @(posedge mclk_in);
      ev[src] <= '{1'b0, !up};
      @(posedge mclk_in);
    end
  endtask
  // emergency circuit, active low only
  task automatic emg(input logic lvl_n);
    @(posedge mclk_in);
    emg_n <= lvl_n;
  endtask
endmodule

// File: sim/esc_top_tb.sv
// self-checking bench for the estop and position counter block
`timescale 1ns/1ps
module esc_top_tb;
  logic mclk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic awvalid_in = 1'b0, wvalid_in = 1'b0, bready_in = 1'b0;
  logic arvalid_in = 1'b0, rready_in = 1'b0;
  logic override2_active_in = 1'b0, override_trigger_input_in = 1'b0;
  logic [7:0] awaddr_in = 8'h00, araddr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0000_0000;
  logic [3:0] wstrb_in = 4'hf, axis_running_in = 4'h0;
  logic [3:0] axis_start_req_in = 4'h0, axis_start_ok_out;
  logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
  logic stop_all_out, int_out, emergency_stop_input_n_in;
  logic [1:0] bresp_out, rresp_out;
  logic [31:0] rdata_out, rd;
  esc_pkg::esc_evt_t out_pulse_in, encoder_inputs_in, pulsar_scaled_in;
  int n_mismatch = 0;
  int tests_run = 0;
  int n_stop = 0;
  always #2 mclk_in = ~mclk_in;
  // one-cycle stop pulses can land while a bus task is waiting, so count
  always @(posedge mclk_in) if (stop_all_out) n_stop <= n_stop + 1;
  esc_top i_esc_top (.*);
  esc_far_model i_esc_far_model (.mclk_in(mclk_in),
    .out_pulse_out(out_pulse_in), .encoder_out(encoder_inputs_in),
    .pulsar_out(pulsar_scaled_in), .emg_n_out(emergency_stop_input_n_in));
  // ==========================================================
  // shared checks and bus cycles
  task automatic give_verdict();
    $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    bit ta = 1'b1, tw = 1'b1, tb = 1'b1;
    @(posedge mclk_in);
    awvalid_in <= 1'b1;
    wvalid_in <= 1'b1;
    awaddr_in <= a;
    wdata_in <= d;
    bready_in <= 1'b1;
    while (tb) begin
      @(posedge mclk_in);
      if (ta && awready_out) begin
        ta = 1'b0;
        awvalid_in <= 1'b0;
      end
      if (tw && wready_out) begin
        tw = 1'b0;
        wvalid_in <= 1'b0;
      end
      if (!ta && !tw && bvalid_out) begin
        tb = 1'b0;
        bready_in <= 1'b0;
        chk("bresp", 32'(bresp_out), 32'(er));
      end
    end
  endtask
  task automatic rdr(input logic [7:0] a, input logic [1:0] er);
    bit tr = 1'b1;
    @(posedge mclk_in);
    arvalid_in <= 1'b1;
    araddr_in <= a;
    rready_in <= 1'b1;
    while (tr) begin
      @(posedge mclk_in);
      if (arvalid_in && arready_out) arvalid_in <= 1'b0;
      if (!arvalid_in && rvalid_out) begin
        tr = 1'b0;
        rready_in <= 1'b0;
        rd = rdata_out;
        chk("rresp", 32'(rresp_out), 32'(er));
      end
    end
  endtask
  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
    rdr(a, esc_pkg::RESP_OKAY);
    chk(n, rd, e);
  endtask
  task automatic start(input logic [3:0] e);
    @(posedge mclk_in);
    axis_start_req_in <= 4'h1;
    @(posedge mclk_in);
    axis_start_req_in <= 4'h0;
    @(negedge mclk_in);
    chk("start_ok", 32'(axis_start_ok_out), 32'(e));
    @(posedge mclk_in); // later stimulus stays on the rising edge
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs();
    rdr(8'h34, esc_pkg::RESP_SLVERR);
    chk("unmapped", rd, 32'h0);
    wr(esc_pkg::OFS_EXT_STATUS, 32'hffff_ffff, esc_pkg::RESP_SLVERR);
    rc("ext_idle", esc_pkg::OFS_EXT_STATUS, 32'h0);
  endtask
  task automatic t_cnt();
    // mechanical on encoder, deflection out minus encoder, general on pulsar
    wr(esc_pkg::OFS_CNT_ENV, 32'h0000_2000, esc_pkg::RESP_OKAY);
    i_esc_far_model.emit(0, 3, 1'b1);
    i_esc_far_model.emit(1, 2, 1'b0);
    i_esc_far_model.emit(2, 4, 1'b1);
    rc("cmd_pos", esc_pkg::OFS_CMD_POS, 32'h3);
    rc("mech_wrap", esc_pkg::OFS_MECH_POS, 32'h0fff_fffe);
    rc("defl", esc_pkg::OFS_DEFL, 32'h5);
    rc("gp", esc_pkg::OFS_GP, 32'h4);
    wr(esc_pkg::OFS_CNT_ENV, 32'h0000_3100, esc_pkg::RESP_OKAY);
    i_esc_far_model.emit(0, 1, 1'b0);
    rc("mech_out", esc_pkg::OFS_MECH_POS, 32'h0fff_fffd);
    rc("gp_off", esc_pkg::OFS_GP, 32'h4);
    // encoder counts up, taking the deflection down past zero, so the 16-bit counter wraps
    i_esc_far_model.emit(1, 5, 1'b1);
    rc("defl_wrap", esc_pkg::OFS_DEFL, 32'h0000_ffff);
  endtask
  task automatic t_pos();
    wr(esc_pkg::OFS_TARGET, 32'h0fff_fffb, esc_pkg::RESP_OKAY);
    start(4'h1);
    rc("load_abs", esc_pkg::OFS_POS_CNT, 32'h5);
    i_esc_far_model.emit(0, 2, 1'b1);
    rc("dec", esc_pkg::OFS_POS_CNT, 32'h3);
    wr(esc_pkg::OFS_OP_MODE, 32'h0000_4000, esc_pkg::RESP_OKAY);
    override2_active_in <= 1'b1;
    start(4'h1);
    i_esc_far_model.emit(0, 2, 1'b1);
    rc("hold", esc_pkg::OFS_POS_CNT, 32'h5);
    override_trigger_input_in <= 1'b1;
    rc("ext_trig", esc_pkg::OFS_EXT_STATUS, 32'h100);
    i_esc_far_model.emit(0, 1, 1'b1);
    rc("release", esc_pkg::OFS_POS_CNT, 32'h4);
    // run the counter down to zero; the pulse from 1 to 0 flags bit 1
    i_esc_far_model.emit(0, 4, 1'b1);
    rc("zero", esc_pkg::OFS_POS_CNT, 32'h0);
    rc("zero_irq", esc_pkg::OFS_INT_STATUS, 32'h2);
    override_trigger_input_in <= 1'b0;
    override2_active_in <= 1'b0;
  endtask
  task automatic t_emg(input bit by_cmd);
    int s0;
    wr(esc_pkg::OFS_INT_MASK, 32'h1, esc_pkg::RESP_OKAY);
    axis_running_in <= 4'h3;
    s0 = n_stop;
    if (by_cmd) wr(esc_pkg::OFS_CMD, 32'h5, esc_pkg::RESP_OKAY);
    else i_esc_far_model.emg(1'b0);
    repeat (4) @(posedge mclk_in);
    @(negedge mclk_in);
    chk("stop_seen", 32'(n_stop != s0), 32'h1);
    chk("irq_set", 32'(int_out), 32'h1);
    rc("cause", esc_pkg::OFS_ERR_CAUSE, 32'h0000_0200);
    if (!by_cmd) rc("ext_emg", esc_pkg::OFS_EXT_STATUS, 32'h81);
    if (!by_cmd) start(4'h0);
    axis_running_in <= 4'h0;
    i_esc_far_model.emg(1'b1);
    wr(esc_pkg::OFS_INT_STATUS, 32'h1, esc_pkg::RESP_OKAY);
    repeat (2) @(posedge mclk_in);
    @(negedge mclk_in);
    chk("irq_clr", 32'(int_out), 32'h0);
    s0 = n_stop;
    wr(esc_pkg::OFS_CMD, 32'h5, esc_pkg::RESP_OKAY);
    repeat (4) @(posedge mclk_in);
    chk("idle_cmd", 32'({n_stop != s0, int_out}), 32'h0);
    // origin return stand-in: a zero target before positioning again
    wr(esc_pkg::OFS_TARGET, 32'h0, esc_pkg::RESP_OKAY);
    start(4'h1);
    rc("origin", esc_pkg::OFS_POS_CNT, 32'h0);
    rc("cause_clr", esc_pkg::OFS_ERR_CAUSE, 32'h0);
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (3) @(posedge mclk_in);
    nrst_in <= 1'b1;
    t_regs();
    t_cnt();
    t_pos();
    t_emg(1'b0);
    t_emg(1'b1);
    give_verdict();
  end
  initial begin
    #40000;
    n_mismatch++;
    give_verdict();
  end
endmodule
